// ---- verilog/stb_tx_ctrl.sv ----
// Purpose: APB register slave, block-move window, transmit FIFO, serializer
//          and transmit pin drive
// Assumes: slot_bit_active comes from highway logic on pclk; the serial
//          clock and the bus-mode pin come from outside and are synchronised
// Notes:   receive FIFO lives elsewhere; reads of the data register pop it
//
// Contract
// [R1] host reserves 16 register addresses and 64 window addresses
// [R2] block-move works only in multiplexed bus mode, set by control bit
// [R3] window access with block-move on goes to data register FIFOs
// [R4] window bit low always decodes as ordinary register access
// [R5] system clock exceeds twice the fastest serial data clock
// [R6] clock-halve select divides the data clock by two internally
// [R7] two select bits choose first, second or both transmit pins
// [R8] shared pin is second data out or active-low slot indicator
// [R9] indicator low continuously when slot feature off and first pin on
// [R10] with slot feature, indicator low only in unmasked slot bits
// [R11] setting transmitter enable starts user data on selected pins
// [R12] enabled with no pin selected: tri-state, FIFO still drains
// [R13] disabled transmitter sends ones on selected pins
// [R14] disabled: ones in slot with feature on, tri-state with it off
// [R15] host writes to the transmit FIFO work while disabled
// [R16] clearing enable does not reset; host issues transmitter reset
// [R17] edge select: 1 launches on rising edge, 0 on falling edge
// [R18] host resets transmitter after changing the edge selection
// [R19] gated clock needs one opposite edge before the first launch
// [R20] transmitter-only reset clears FIFO pointers and serializer
// [R21] outputs tri-state outside assigned slot and in masked bits
// [R22] clock edges found by sampling in pclk domain
`timescale 1ns/1ps
module stb_tx_ctrl
  import stb_pkg::*;
#(
  parameter int FIFO_DEPTH = 64,
  parameter int PTR_W      = 6
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        muxed_bus_mode,
  input  wire logic        serial_tx_clock,
  input  wire logic        slot_bit_active,
  input  wire logic [7:0]  rx_fifo_data,
  output      logic        rx_fifo_pop,
  output      logic        tx_data_out_first,
  output      logic        tx_first_oe,
  output      logic        tx_data_out_second,
  output      logic        tx_second_oe
);

  import stb_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (FIFO_DEPTH != (1 << PTR_W) || PTR_W < 1 || PTR_W > 7) begin : g_chk
    $error("fifo depth must be a power of two matching the pointer width");
  end
  // see [R5]
  if (PCLK_KHZ <= 2 * SERIAL_RATE_MAX_KHZ) begin : g_rate
    $error("pclk too slow for the fastest serial data clock");
  end

  localparam logic [PTR_W:0] DEPTH_V = (PTR_W+1)'(FIFO_DEPTH);

  // ----------------------------------------------------------------------
  // synchronisers and edge finder
  // ----------------------------------------------------------------------
  logic [1:0] pins_sync;
  logic       mux_mode;
  logic       txclk_lvl;
  logic       launch;
  logic       do_tx_reset;

  stb_sync2 #(.WIDTH(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({muxed_bus_mode, serial_tx_clock}),
    .q       (pins_sync)
  );
  assign mux_mode  = pins_sync[1];
  assign txclk_lvl = pins_sync[0];

  logic [7:0] reg_global;
  logic [7:0] reg_rx_ctrl;
  logic [7:0] reg_tx_slot;
  logic [7:0] reg_rx_slot;
  logic [7:0] reg_clk_edge;
  logic       tx_enable;

  stb_tx_edge u_edge (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_level  (txclk_lvl),
    .halve      (reg_rx_slot[BIT_CLK_HALVE]),
    .rising_sel (reg_clk_edge[BIT_TX_EDGE]),
    .restart    (do_tx_reset),
    .launch     (launch)
  );

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic [REG_IDX_W-1:0] idx;
  logic                 addr_ok;
  logic                 in_window;
  logic                 win_hit;
  logic [3:0]           eff_idx;
  logic                 dec_err;
  logic                 xfer_done;
  logic                 wr_ok;
  logic                 soft_reset;
  logic                 do_push;

  assign idx       = paddr[REG_IDX_W+1:2];
  assign addr_ok   = (paddr[31:REG_IDX_W+2] == '0) && (paddr[1:0] == 2'b00);
  assign in_window = idx[WINDOW_BIT];
  // window only translates with block-move on and the bus multiplexed
  assign win_hit   = in_window & reg_global[BIT_BLOCKMOVE_EN]
                     & mux_mode;                         // see [R2] see [R3]
  always_comb begin
    if (!addr_ok) begin
      eff_idx = 4'h0;
      dec_err = 1'b1;
    end else if (win_hit) begin
      eff_idx = IDX_FIFO_DATA;                           // see [R3] see [R1]
      dec_err = 1'b0;
    end else if (!in_window && idx[5:4] == 2'b00) begin
      eff_idx = idx[3:0];                                // see [R4]
      dec_err = 1'b0;
    end else begin
      eff_idx = 4'h0;
      dec_err = 1'b1;
    end
  end

  assign xfer_done   = psel & penable & pready;
  assign wr_ok       = xfer_done & pwrite & ~dec_err;
  assign soft_reset  = wr_ok && eff_idx == IDX_TXRX_CMD
                       && pwdata[BIT_TX_RESET] && pwdata[BIT_RX_RESET];
  assign do_tx_reset = soft_reset || (wr_ok && eff_idx == IDX_TXRX_CMD
                       && pwdata[BIT_TX_RESET]
                       && !pwdata[BIT_RX_RESET]);        // see [R20] see [R16]
  assign do_push     = wr_ok && eff_idx == IDX_FIFO_DATA; // see [R15]

  // ----------------------------------------------------------------------
  // register file and bus answer
  // ----------------------------------------------------------------------
  logic [PTR_W:0] fifo_cnt;
  logic [7:0]     next_global;
  logic [7:0]     next_rx_ctrl;
  logic [7:0]     next_tx_slot;
  logic [7:0]     next_rx_slot;
  logic [7:0]     next_clk_edge;
  logic           next_tx_enable;
  logic           next_pready;
  logic [31:0]    next_prdata;
  logic           next_pslverr;
  logic           next_rx_pop;
  logic [PTR_W:0] free_space;

  assign free_space = DEPTH_V - fifo_cnt;

  always_comb begin
    next_global    = reg_global;
    next_rx_ctrl   = reg_rx_ctrl;
    next_tx_slot   = reg_tx_slot;
    next_rx_slot   = reg_rx_slot;
    next_clk_edge  = reg_clk_edge;
    next_tx_enable = tx_enable;
    next_prdata    = prdata;
    next_pslverr   = pslverr;
    // one wait state keeps read data and error straight from flops
    next_pready    = psel & penable & ~pready;
    next_rx_pop    = xfer_done & ~pwrite & ~dec_err
                     & (eff_idx == IDX_FIFO_DATA);       // see [R3]
    if (psel && penable && !pready) begin
      next_pslverr = dec_err;
      next_prdata  = RST_WORD;
      if (!dec_err && !pwrite) begin
        if (eff_idx == IDX_GLOBAL_CFG) begin
          next_prdata[7:0] = reg_global;
        end else if (eff_idx == IDX_TX_STATUS) begin
          next_prdata[PTR_W:0] = free_space;
        end else if (eff_idx == IDX_FIFO_DATA) begin
          next_prdata[7:0] = rx_fifo_data;
        end else if (eff_idx == IDX_RX_CTRL) begin
          next_prdata[7:0] = reg_rx_ctrl;
        end else if (eff_idx == IDX_TXRX_CMD) begin
          next_prdata[BIT_TX_ENABLE] = tx_enable;
        end else if (eff_idx == IDX_TX_SLOT) begin
          next_prdata[7:0] = reg_tx_slot;
        end else if (eff_idx == IDX_RX_SLOT) begin
          next_prdata[7:0] = reg_rx_slot;
        end else if (eff_idx == IDX_CLK_EDGE) begin
          next_prdata[7:0] = reg_clk_edge;
        end
      end
    end
    if (soft_reset) begin
      next_global    = RST_BYTE;
      next_rx_ctrl   = RST_BYTE;
      next_tx_slot   = RST_BYTE;
      next_rx_slot   = RST_BYTE;
      next_clk_edge  = RST_BYTE;
      next_tx_enable = 1'b0;
    end else if (wr_ok) begin
      if (eff_idx == IDX_GLOBAL_CFG) begin
        next_global = pwdata[7:0];                       // see [R2]
      end else if (eff_idx == IDX_RX_CTRL) begin
        next_rx_ctrl = pwdata[7:0];                      // see [R8]
      end else if (eff_idx == IDX_TXRX_CMD) begin
        // clearing enable leaves FIFO, shift register and state untouched; the output bit goes idle
        next_tx_enable = pwdata[BIT_TX_ENABLE];          // see [R11] see [R16]
      end else if (eff_idx == IDX_TX_SLOT) begin
        next_tx_slot = pwdata[7:0];                      // see [R7]
      end else if (eff_idx == IDX_RX_SLOT) begin
        next_rx_slot = pwdata[7:0];                      // see [R6]
      end else if (eff_idx == IDX_CLK_EDGE) begin
        next_clk_edge = pwdata[7:0];                     // see [R17] see [R18]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_global   <= RST_BYTE;
      reg_rx_ctrl  <= RST_BYTE;
      reg_tx_slot  <= RST_BYTE;
      reg_rx_slot  <= RST_BYTE;
      reg_clk_edge <= RST_BYTE;
      tx_enable    <= 1'b0;
      pready       <= 1'b0;
      prdata       <= RST_WORD;
      pslverr      <= 1'b0;
      rx_fifo_pop  <= 1'b0;
    end else begin
      reg_global   <= next_global;
      reg_rx_ctrl  <= next_rx_ctrl;
      reg_tx_slot  <= next_tx_slot;
      reg_rx_slot  <= next_rx_slot;
      reg_clk_edge <= next_clk_edge;
      tx_enable    <= next_tx_enable;
      pready       <= next_pready;
      prdata       <= next_prdata;
      pslverr      <= next_pslverr;
      rx_fifo_pop  <= next_rx_pop;
    end
  end

  // ----------------------------------------------------------------------
  // transmit FIFO and serializer
  // ----------------------------------------------------------------------
  logic [7:0]     mem [FIFO_DEPTH];
  logic [7:0]     next_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [PTR_W:0]   next_cnt;
  logic [7:0]       shreg;
  logic [7:0]       next_shreg;
  logic [2:0]       bits_left;
  logic [2:0]       next_bits_left;
  logic             tx_bit;
  logic             next_tx_bit;
  stb_tx_state_t    tx_state;
  stb_tx_state_t    next_tx_state;
  logic             hwy_on;
  logic             shift_now;
  logic             pop;

  assign hwy_on    = reg_global[BIT_TIMESLOT_EN];
  // shifting ignores pin selection, so an unrouted stream still drains
  assign shift_now = launch & tx_enable
                     & (~hwy_on | slot_bit_active);      // see [R12] see [R21]

  always_comb begin
    next_mem       = mem;
    next_wr_ptr    = wr_ptr;
    next_rd_ptr    = rd_ptr;
    next_shreg     = shreg;
    next_bits_left = bits_left;
    next_tx_bit    = tx_bit;
    next_tx_state  = tx_state;
    pop            = 1'b0;
    if (!tx_enable) begin
      next_tx_bit = RST_IDLE_BIT;                        // see [R13]
    end else if (shift_now) begin
      case (tx_state)
        STB_TX_IDLE: begin
          if (fifo_cnt != '0) begin
            pop            = 1'b1;
            next_tx_bit    = mem[rd_ptr][0];             // see [R11]
            next_shreg     = {1'b0, mem[rd_ptr][7:1]};
            next_bits_left = 3'h7;
            next_rd_ptr    = rd_ptr + 1'b1;
            next_tx_state  = STB_TX_SHIFT;
          end else begin
            next_tx_bit = RST_IDLE_BIT;
          end
        end
        STB_TX_SHIFT: begin
          next_tx_bit    = shreg[0];
          next_shreg     = {1'b0, shreg[7:1]};
          next_bits_left = bits_left - 1'b1;
          if (bits_left == 3'h1) begin
            next_tx_state = STB_TX_IDLE;
          end
        end
        default: next_tx_state = STB_TX_IDLE;
      endcase
    end
    next_cnt = fifo_cnt - {{PTR_W{1'b0}}, pop};
    if (do_push) begin
      if (fifo_cnt == DEPTH_V && !pop) begin
        // overrun rewrites the newest byte instead of growing
        next_mem[wr_ptr - 1'b1] = pwdata[7:0];
      end else begin
        next_mem[wr_ptr] = pwdata[7:0];                  // see [R15]
        next_wr_ptr      = wr_ptr + 1'b1;
        next_cnt         = next_cnt + 1'b1;
      end
    end
    if (do_tx_reset) begin
      next_wr_ptr    = '0;                               // see [R20]
      next_rd_ptr    = '0;
      next_cnt       = '0;
      next_bits_left = 3'h0;
      next_tx_bit    = RST_IDLE_BIT;
      next_tx_state  = STB_TX_IDLE;
    end
  end

  for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_mem
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem[i] <= RST_BYTE;
      end else begin
        mem[i] <= next_mem[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      fifo_cnt  <= '0;
      shreg     <= RST_BYTE;
      bits_left <= 3'h0;
      tx_bit    <= RST_IDLE_BIT;
      tx_state  <= STB_TX_IDLE;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      fifo_cnt  <= next_cnt;
      shreg     <= next_shreg;
      bits_left <= next_bits_left;
      tx_bit    <= next_tx_bit;
      tx_state  <= next_tx_state;
    end
  end

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  logic sel_first;
  logic sel_second;
  logic shared_ind;
  logic in_slot;
  logic may_drive;
  logic next_out_first;
  logic next_oe_first;
  logic next_out_second;
  logic next_oe_second;

  assign sel_first  = reg_tx_slot[BIT_FIRST_SEL];
  assign sel_second = reg_tx_slot[BIT_SECOND_SEL];
  assign shared_ind = reg_rx_ctrl[BIT_SHARED_FN];
  assign in_slot    = ~hwy_on | slot_bit_active;         // see [R21]
  // disabled and no slot feature means no drive on the data pins
  assign may_drive  = tx_enable | hwy_on;                // see [R14]

  always_comb begin
    next_oe_first   = sel_first & in_slot & may_drive;   // see [R7] see [R12]
    next_out_first  = tx_enable ? tx_bit : RST_IDLE_BIT; // see [R13]
    if (shared_ind) begin
      // indicator drives always; second-pin select is ignored
      next_oe_second  = 1'b1;                            // see [R8]
      next_out_second = ~(sel_first & in_slot);          // see [R9] see [R10]
    end else begin
      next_oe_second  = sel_second & in_slot & may_drive; // see [R7]
      next_out_second = next_out_first;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_out_first  <= RST_IDLE_BIT;
      tx_first_oe        <= 1'b0;
      tx_data_out_second <= RST_IDLE_BIT;
      tx_second_oe       <= 1'b0;
    end else begin
      tx_data_out_first  <= next_out_first;
      tx_first_oe        <= next_oe_first;
      tx_data_out_second <= next_out_second;
      tx_second_oe       <= next_oe_second;
    end
  end

endmodule : stb_tx_ctrl

// ---- verilog/stb_pkg.sv ----
// Purpose: shared constants for the serial transmit pin and block-move block
// Assumes: registers are byte wide and sit in the low bits of 32-bit words
// Notes:   register indices are word indices; byte address is index times 4
package stb_pkg;

  // ----------------------------------------------------------------------
  // register map (word indices)
  // ----------------------------------------------------------------------
  localparam int          REG_IDX_W        = 7;
  localparam logic [3:0]  IDX_GLOBAL_CFG   = 4'h0;
  localparam logic [3:0]  IDX_TX_STATUS    = 4'h2;
  localparam logic [3:0]  IDX_FIFO_DATA    = 4'h3;
  localparam logic [3:0]  IDX_RX_CTRL      = 4'h5;
  localparam logic [3:0]  IDX_TXRX_CMD     = 4'h6;
  localparam logic [3:0]  IDX_TX_SLOT      = 4'h7;
  localparam logic [3:0]  IDX_RX_SLOT      = 4'h8;
  localparam logic [3:0]  IDX_CLK_EDGE     = 4'h9;
  localparam int          WINDOW_BIT       = 6;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_TIMESLOT_EN   = 7;
  localparam int BIT_BLOCKMOVE_EN  = 3;
  localparam int BIT_TX_RESET      = 5;
  localparam int BIT_RX_RESET      = 4;
  localparam int BIT_TX_ENABLE     = 3;
  localparam int BIT_FIRST_SEL     = 7;
  localparam int BIT_SECOND_SEL    = 6;
  localparam int BIT_SHARED_FN     = 7;
  localparam int BIT_CLK_HALVE     = 6;
  localparam int BIT_TX_EDGE       = 4;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [31:0] RST_WORD         = 32'h0000_0000;
  localparam logic        RST_IDLE_BIT     = 1'b1;

  // ----------------------------------------------------------------------
  // timing limits
  // ----------------------------------------------------------------------
  localparam int SERIAL_RATE_MAX_KHZ = 4096;
  localparam int PCLK_KHZ            = 25000;
  localparam int PCLK_PERIOD_NS      = 1000000 / PCLK_KHZ;

  // ----------------------------------------------------------------------
  // serializer states
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    STB_TX_IDLE  = 1'b0,
    STB_TX_SHIFT = 1'b1
  } stb_tx_state_t;

endpackage : stb_pkg

// ---- verilog/stb_sync2.sv ----
// Purpose: two-flop synchroniser for levels arriving from outside pclk
// Assumes: each bit is an independent level
// Notes:   only the second stage is visible to logic
`timescale 1ns/1ps
module stb_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output      logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule : stb_sync2

// ---- verilog/stb_tx_edge.sv ----
// Purpose: find the programmed launch edge of the sampled transmit clock
// Assumes: clk_level is already synchronised to pclk
// Notes:   launch is a one-cycle pulse; halving counts rising edges
`timescale 1ns/1ps
module stb_tx_edge (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_level,
  input  wire logic halve,
  input  wire logic rising_sel,
  input  wire logic restart,
  output      logic launch
);

  logic prev;
  logic div;
  logic armed;
  logic next_div;
  logic next_armed;
  logic next_launch;
  logic rise;
  logic fall;
  logic eff_rise;
  logic eff_fall;
  logic want;
  logic opp;

  always_comb begin
    rise        = clk_level & ~prev;
    fall        = ~clk_level & prev;
    // halved clock rises on every other raw rising edge
    eff_rise    = halve ? (rise & ~div) : rise;  // see [R6]
    eff_fall    = halve ? (rise & div) : fall;   // see [R6]
    want        = rising_sel ? eff_rise : eff_fall;  // see [R17]
    opp         = rising_sel ? eff_fall : eff_rise;
    next_div    = restart ? 1'b0 : (div ^ rise);
    // a launch edge counts only after one opposite edge was seen
    next_armed  = restart ? 1'b0 : (armed | opp);  // see [R19]
    next_launch = want & armed & ~restart;          // see [R22]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev   <= 1'b0;
      div    <= 1'b0;
      armed  <= 1'b0;
      launch <= 1'b0;
    end else begin
      prev   <= clk_level;
      div    <= next_div;
      armed  <= next_armed;
      launch <= next_launch;
    end
  end

endmodule : stb_tx_edge

// ---- verification/stb_tx_props_properties.sv ----
// Purpose: port checks for stb_tx_ctrl
// Assumes: config is tracked from completed apb writes
// Notes:   pins are registered, so expectations look one cycle back
`timescale 1ns/1ps
module stb_tx_props #(
  parameter int FIFO_DEPTH = 64,
  parameter int PTR_W      = 6
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        muxed_bus_mode,
  input wire logic        serial_tx_clock,
  input wire logic        slot_bit_active,
  input wire logic [7:0]  rx_fifo_data,
  input wire logic        rx_fifo_pop,
  input wire logic        tx_data_out_first,
  input wire logic        tx_first_oe,
  input wire logic        tx_data_out_second,
  input wire logic        tx_second_oe
);
  // -----
  // shadow config
  // -----
  logic ts, bm, fn, s1, s2, en;
  wire  wr = psel && penable && pready && pwrite;
  wire  rd = psel && penable && pready && !pwrite;
  wire  g  = ts ? slot_bit_active : 1'b1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {ts, bm, fn, s1, s2, en} <= '0;
    else if (wr && paddr == 32'h18 && pwdata[5] && pwdata[4])
      {ts, bm, fn, s1, s2, en} <= '0;
    else if (wr) case (paddr)
      32'h00: {ts, bm} <= {pwdata[7], pwdata[3]};
      32'h14: fn <= pwdata[7];
      32'h18: en <= pwdata[3];
      32'h1C: {s1, s2} <= pwdata[7:6];
      default: ;
    endcase
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; !pready ##1 pready; endsequence
  a_one_wait: assert property (s_setup |=> s_answer)
    else $error("pready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_first_oe: assert property (
    tx_first_oe == $past(s1 && g && (en || ts)))
    else $error("first pin enable wrong");
  a_first_ones: assert property (
    !$past(en) |-> tx_data_out_first)
    else $error("disabled first pin not one");
  a_ind_pin: assert property ($past(fn) |->
    tx_second_oe && tx_data_out_second == !$past(s1 && g))
    else $error("slot indicator wrong");
  a_second_oe: assert property (!$past(fn)
    |-> tx_second_oe == $past(s2 && g && (en || ts)))
    else $error("second pin enable wrong");
  a_both_same: assert property (
    tx_first_oe && tx_second_oe && !$past(fn)
    |-> tx_data_out_first == tx_data_out_second)
    else $error("pins differ");
  a_pop_map: assert property (
    rx_fifo_pop == $past(rd && !pslverr
    && (paddr[8] || paddr[8:2] == 7'h03)))
    else $error("receive pop wrong");
  a_window_off: assert property (
    pready && paddr[8] && !bm |-> pslverr)
    else $error("window open while block move off");
endmodule : stb_tx_props
bind stb_tx_ctrl stb_tx_props #(.FIFO_DEPTH(FIFO_DEPTH), .PTR_W(PTR_W))
  u_props (.*);

// ---- verification/stb_far_end.sv ----
// Purpose: far end: gated serial clock source and bit receiver
// Assumes: launch on falling edge, bits arrive lsb first
// Notes:   clock idles low so a frame opens with a rising edge
`timescale 1ns/1ps
module stb_far_end (
  input  wire logic       start,
  input  wire logic [3:0] nbytes,
  input  wire logic       line,
  output      logic       serial_tx_clock,
  output      logic [7:0] rx_byte,
  output      logic       rx_valid
);
  logic [7:0] sh;
  initial begin
    serial_tx_clock = 1'b0;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    sh = 8'h00;
  end
  // sample at the launch edge, before the pin moves on
  always @(posedge start) begin
    #10;
    for (int i = 0; i <= 8 * nbytes; i++) begin
      #160 serial_tx_clock = 1'b1;
      #160 serial_tx_clock = 1'b0;
      if (i > 0) sh = {line, sh[7:1]};
      if (i > 0 && i % 8 == 0) begin
        rx_byte = sh;
        rx_valid = 1'b1;
        #1 rx_valid = 1'b0;
      end
    end
  end
endmodule : stb_far_end

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for stb_tx_ctrl
// Assumes: falling launch edge, far end clock of 320 ns
// Notes:   serial bytes are checked through a queue of expected values
`timescale 1ns/1ps
module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, sba = 1'b0, go = 1'b0, mbm = 1'b1, e;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r, seed, sseed;
  logic [7:0]  rxd = 8'h00, rb;
  logic        pready, pslverr, pop, o1, oe1, o2, oe2, sclk, rv;
  logic [3:0]  nb = 4'h0;
  logic [7:0]  expq[$];
  int          failures = 0;
  int          comparisons = 0;
  always #20 pclk = ~pclk;
  stb_tx_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .muxed_bus_mode(mbm), .serial_tx_clock(sclk), .slot_bit_active(sba),
    .rx_fifo_data(rxd), .rx_fifo_pop(pop), .tx_data_out_first(o1),
    .tx_first_oe(oe1), .tx_data_out_second(o2), .tx_second_oe(oe2));
  // released line reads high through the pull-up
  stb_far_end far_u (.start(go), .nbytes(nb), .line(oe1 ? o1 : 1'b1),
    .serial_tx_clock(sclk), .rx_byte(rb), .rx_valid(rv));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [31:0] a, x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk({31'h0, e}, {31'h0, xe}, "error flag");
    if (!xe) chk(r, x, "read data");
  endtask : rd_chk
  task automatic wrap_up;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  always @(posedge pclk) begin
    sseed <= lfsr(sseed);
    sba <= sseed[0];
  end
  always @(posedge rv) begin
    if (expq.size() == 0) chk(32'h1, 32'h0, "unexpected byte");
    else chk({24'h0, rb}, {24'h0, expq.pop_front()},
      "serial byte");
  end
  initial begin
    #200us;
    failures++;
    wrap_up;
  end
  initial begin
    seed = 32'hDC04BFAD;
    sseed = seed;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rxd <= 8'h5A;
    rd_chk(32'h08, 32'h40, 1'b0);
    rd_chk(32'h100, 32'h0, 1'b1);
    rd_chk(32'h0C, 32'h5A, 1'b0);
    apb(1'b1, 32'h00, 32'h08);
    rd_chk(32'h1FC, 32'h5A, 1'b0);
    mbm <= 1'b0;
    repeat (2) @(posedge pclk);
    rd_chk(32'h1FC, 32'h0, 1'b1);
    mbm <= 1'b1;
    apb(1'b1, 32'h1C, 32'h80);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      expq.push_back(seed[7:0]);
      apb(1'b1, i[0] ? 32'h0C : 32'h100 + 32'(4 * i),
        {24'h0, seed[7:0]});
    end
    rd_chk(32'h08, 32'h3C, 1'b0);
    apb(1'b1, 32'h18, 32'h08);
    nb <= 4'h4;
    go <= 1'b1;
    while (expq.size() != 0) @(posedge pclk);
    go <= 1'b0;
    rd_chk(32'h08, 32'h40, 1'b0);
    for (int k = 0; k < 32; k++) begin
      apb(1'b1, 32'h1C, {24'h0, k[1:0], 6'h0});
      apb(1'b1, 32'h14, {24'h0, k[2], 7'h0});
      apb(1'b1, 32'h00, {24'h0, k[3], 7'h0});
      apb(1'b1, 32'h18, {28'h0, k[4], 3'h0});
      repeat (4) @(posedge pclk);
    end
    apb(1'b1, 32'h0C, 32'h11);
    apb(1'b1, 32'h24, 32'h00);
    apb(1'b1, 32'h18, 32'h20);
    rd_chk(32'h08, 32'h40, 1'b0);
    apb(1'b1, 32'h0C, 32'hA5);
    rd_chk(32'h08, 32'h3F, 1'b0);
    apb(1'b1, 32'h00, 32'h00);
    apb(1'b1, 32'h1C, 32'h00);
    apb(1'b1, 32'h14, 32'h00);
    apb(1'b1, 32'h18, 32'h08);
    expq.push_back(8'hFF);
    nb <= 4'h1;
    go <= 1'b1;
    while (expq.size() != 0) @(posedge pclk);
    rd_chk(32'h08, 32'h40, 1'b0);
    wrap_up;
  end
endmodule : tb_top
